// ==== verilog/ecpwm_cfg.svh ====
`ifndef ECPWM_CFG_SVH
`define ECPWM_CFG_SVH
// Capture/compare mode field encodings
`define ECPWM_MODE_OFF      4'h0
`define ECPWM_MODE_FALL     4'h4
`define ECPWM_MODE_RISE     4'h5
`define ECPWM_MODE_RISE4    4'h6
`define ECPWM_MODE_RISE16   4'h7
`define ECPWM_MODE_PWM      4'hC
// Bridge steering encodings
`define ECPWM_BR_SINGLE     2'h0
`define ECPWM_BR_FWD        2'h1
`define ECPWM_BR_HALF       2'h2
`define ECPWM_BR_REV        2'h3
// Prescaled edge counts
`define ECPWM_DIV4_LAST     4'h3
`define ECPWM_DIV16_LAST    4'hF
`endif

// ==== verilog/ecpwm_pkg.sv ====
package ecpwm_pkg;
    typedef logic [3:0] ecpwm_mode_t;
    typedef logic [1:0] ecpwm_bridge_t;
endpackage

// ==== verilog/ecpwm_top.sv ====
`timescale 1ns/1ps
`include "ecpwm_cfg.svh"
// Summary of operation
// - Four-bit mode selects rising or falling capture
// - Edge latches time base, raises enabled irq
// - PWM output has ten-bit duty resolution
// - Enhanced variant routes PWM to outputs A-D
// - Single mode drives output A only
// - Half-bridge drives complementary A and B only
// - Full-bridge forward and reverse drive four outputs
// - Pair A/C and B/D polarity selectable
// - Capture copies sixteen-bit count, high/low bytes
// - Mode also captures every fourth/sixteenth rise
module ecpwm_top #(
    parameter int PWM_BITS = 10
) (
    // Clock and reset
    input  wire logic                     SYS_CLK_IN,
    input  wire logic                     SRST_IN,
    // Control
    input  wire ecpwm_pkg::ecpwm_mode_t   CAPTURE_MODE_FIELD_IN,
    input  wire ecpwm_pkg::ecpwm_bridge_t BRIDGE_MODE_IN,
    input  wire logic                     POL_AC_LOW_IN,
    input  wire logic                     POL_BD_LOW_IN,
    input  wire logic                     CAPTURE_IRQ_ENABLE_IN,
    input  wire logic                     CAPTURE_FLAG_CLR_IN,
    // Time base and duty
    input  wire logic [15:0]              CAPTURE_TIME_BASE_IN,
    input  wire logic [PWM_BITS-1:0]      PWM_PERIOD_IN,
    input  wire logic [PWM_BITS-1:0]      PWM_DUTY_IN,
    // Pin
    input  wire logic                     CAP_PWM_PIN_IN,
    // Status
    output logic [7:0]                    CAPTURE_VALUE_HIGH_OUT,
    output logic [7:0]                    CAPTURE_VALUE_LOW_OUT,
    output logic                          CAPTURE_FLAG_OUT,
    output logic                          CAPTURE_IRQ_OUT,
    // Outputs
    output logic                          CAP_PWM_PIN_OUT,
    output logic                          BRIDGE_OUT_A_OUT,
    output logic                          BRIDGE_OUT_B_OUT,
    output logic                          BRIDGE_OUT_C_OUT,
    output logic                          BRIDGE_OUT_D_OUT,
    output logic [3:0]                    BRIDGE_OE_OUT
);
    logic                pin_q,  pin_d;
    logic [3:0]          pre_q,  pre_d;
    logic [15:0]         cap_q,  cap_d;
    logic                flag_q, flag_d;
    logic [PWM_BITS-1:0] cnt_q,  cnt_d;
    logic                pwm_q,  pwm_d;
    logic [3:0]          br_q,   br_d;
    logic [3:0]          oe_q,   oe_d;
    logic                rise;
    logic                fall;
    logic                hit;
    logic                pwm_mode;

    assign rise     = CAP_PWM_PIN_IN & ~pin_q;
    assign fall     = ~CAP_PWM_PIN_IN & pin_q;
    assign pwm_mode = ((CAPTURE_MODE_FIELD_IN & `ECPWM_MODE_PWM) == `ECPWM_MODE_PWM);

    always_comb begin
        hit   = 1'b0;
        pin_d = CAP_PWM_PIN_IN;
        pre_d = pre_q;
        unique case (CAPTURE_MODE_FIELD_IN)
            `ECPWM_MODE_FALL:   hit = fall;
            `ECPWM_MODE_RISE:   hit = rise;
            `ECPWM_MODE_RISE4: begin
                if (rise) pre_d = ({2'h0, pre_q[1:0]} == `ECPWM_DIV4_LAST) ? 4'h0 : pre_q + 4'h1;
                hit = rise && ({2'h0, pre_q[1:0]} == `ECPWM_DIV4_LAST);
            end
            `ECPWM_MODE_RISE16: begin
                if (rise) pre_d = pre_q + 4'h1;
                hit = rise && (pre_q == `ECPWM_DIV16_LAST);
            end
            default: pre_d = 4'h0;
        endcase
        cap_d  = hit ? CAPTURE_TIME_BASE_IN : cap_q;
        flag_d = hit | (flag_q & ~CAPTURE_FLAG_CLR_IN);
    end

    always_comb begin
        cnt_d = (cnt_q >= PWM_PERIOD_IN) ? '0 : cnt_q + 1'b1;
        pwm_d = pwm_mode && (cnt_d < PWM_DUTY_IN);
        br_d  = 4'h0;
        oe_d  = 4'h0;
        if (pwm_mode) begin
            unique case (BRIDGE_MODE_IN)
                `ECPWM_BR_SINGLE: begin
                    br_d = {3'h0, pwm_d};
                    oe_d = 4'h1;
                end
                `ECPWM_BR_HALF: begin
                    br_d = {2'h0, ~pwm_d, pwm_d};
                    oe_d = 4'h3;
                end
                `ECPWM_BR_FWD: begin
                    br_d = {pwm_d, 2'h0, 1'b1};
                    oe_d = 4'hF;
                end
                `ECPWM_BR_REV: begin
                    br_d = {1'b0, 1'b1, pwm_d, 1'b0};
                    oe_d = 4'hF;
                end
            endcase
            br_d = br_d ^ {POL_BD_LOW_IN, POL_AC_LOW_IN, POL_BD_LOW_IN, POL_AC_LOW_IN};
        end
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (SRST_IN) begin
            pin_q  <= 1'b0;
            pre_q  <= 4'h0;
            cap_q  <= 16'h0000;
            flag_q <= 1'b0;
            cnt_q  <= '0;
            pwm_q  <= 1'b0;
            br_q   <= 4'h0;
            oe_q   <= 4'h0;
        end else begin
            pin_q  <= pin_d;
            pre_q  <= pre_d;
            cap_q  <= cap_d;
            flag_q <= flag_d;
            cnt_q  <= cnt_d;
            pwm_q  <= pwm_d;
            br_q   <= br_d;
            oe_q   <= oe_d;
        end
    end

    assign CAPTURE_VALUE_HIGH_OUT = cap_q[15:8];
    assign CAPTURE_VALUE_LOW_OUT  = cap_q[7:0];
    assign CAPTURE_FLAG_OUT       = flag_q;
    assign CAPTURE_IRQ_OUT        = flag_q & CAPTURE_IRQ_ENABLE_IN;
    assign CAP_PWM_PIN_OUT        = pwm_q;
    assign BRIDGE_OUT_A_OUT       = br_q[0];
    assign BRIDGE_OUT_B_OUT       = br_q[1];
    assign BRIDGE_OUT_C_OUT       = br_q[2];
    assign BRIDGE_OUT_D_OUT       = br_q[3];
    assign BRIDGE_OE_OUT          = oe_q;

    property p_capture_latch;
        @(posedge SYS_CLK_IN) disable iff (SRST_IN)
        (CAPTURE_MODE_FIELD_IN == `ECPWM_MODE_RISE && rise)
        |=> ({CAPTURE_VALUE_HIGH_OUT, CAPTURE_VALUE_LOW_OUT} == $past(CAPTURE_TIME_BASE_IN)
             && CAPTURE_FLAG_OUT);
    endproperty
    a_capture_latch: assert property (p_capture_latch) else $error("rise capture missed");

    property p_fall_latch;
        @(posedge SYS_CLK_IN) disable iff (SRST_IN)
        (CAPTURE_MODE_FIELD_IN == `ECPWM_MODE_FALL && fall) |=> CAPTURE_FLAG_OUT;
    endproperty
    a_fall_latch: assert property (p_fall_latch) else $error("fall capture missed");

    property p_irq_gate;
        @(posedge SYS_CLK_IN) disable iff (SRST_IN)
        CAPTURE_IRQ_OUT |-> (CAPTURE_FLAG_OUT && CAPTURE_IRQ_ENABLE_IN);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");

    property p_flag_sticky;
        @(posedge SYS_CLK_IN) disable iff (SRST_IN)
        (CAPTURE_FLAG_OUT && !CAPTURE_FLAG_CLR_IN) |=> CAPTURE_FLAG_OUT;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");

    property p_hold_value;
        @(posedge SYS_CLK_IN) disable iff (SRST_IN)
        !hit |=> $stable({CAPTURE_VALUE_HIGH_OUT, CAPTURE_VALUE_LOW_OUT});
    endproperty
    a_hold_value: assert property (p_hold_value) else $error("value changed");

    property p_div16;
        @(posedge SYS_CLK_IN) disable iff (SRST_IN)
        (CAPTURE_MODE_FIELD_IN == `ECPWM_MODE_RISE16 && !(rise && pre_q == `ECPWM_DIV16_LAST))
        |=> $stable({CAPTURE_VALUE_HIGH_OUT, CAPTURE_VALUE_LOW_OUT});
    endproperty
    a_div16: assert property (p_div16) else $error("early div16 capture");

    property p_single;
        @(posedge SYS_CLK_IN) disable iff (SRST_IN)
        (pwm_mode && BRIDGE_MODE_IN == `ECPWM_BR_SINGLE) |=> (BRIDGE_OE_OUT == 4'h1);
    endproperty
    a_single: assert property (p_single) else $error("single drives extra pins");

    property p_half;
        @(posedge SYS_CLK_IN) disable iff (SRST_IN)
        (pwm_mode && BRIDGE_MODE_IN == `ECPWM_BR_HALF && !POL_AC_LOW_IN && !POL_BD_LOW_IN)
        |=> (BRIDGE_OUT_A_OUT != BRIDGE_OUT_B_OUT);
    endproperty
    a_half: assert property (p_half) else $error("half not complementary");

    property p_pwm_off;
        @(posedge SYS_CLK_IN) disable iff (SRST_IN)
        (pwm_mode && PWM_DUTY_IN == '0) |=> !CAP_PWM_PIN_OUT;
    endproperty
    a_pwm_off: assert property (p_pwm_off) else $error("zero duty drives high");

    property p_div4;
        @(posedge SYS_CLK_IN) disable iff (SRST_IN)
        (CAPTURE_MODE_FIELD_IN == `ECPWM_MODE_RISE4 && rise
            && {2'h0, pre_q[1:0]} == `ECPWM_DIV4_LAST)
        |=> ({CAPTURE_VALUE_HIGH_OUT, CAPTURE_VALUE_LOW_OUT} == $past(CAPTURE_TIME_BASE_IN)
             && CAPTURE_FLAG_OUT);
    endproperty
    a_div4: assert property (p_div4) else $error("fourth rise capture missed");

    property p_irq_raise;
        @(posedge SYS_CLK_IN) disable iff (SRST_IN)
        (hit && CAPTURE_IRQ_ENABLE_IN) |=> (CAPTURE_IRQ_OUT || !CAPTURE_IRQ_ENABLE_IN);
    endproperty
    a_irq_raise: assert property (p_irq_raise) else $error("capture irq missed");

    property p_flag_clear;
        @(posedge SYS_CLK_IN) disable iff (SRST_IN)
        (CAPTURE_FLAG_CLR_IN && !hit) |=> !CAPTURE_FLAG_OUT;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

    property p_fwd;
        @(posedge SYS_CLK_IN) disable iff (SRST_IN)
        (pwm_mode && BRIDGE_MODE_IN == `ECPWM_BR_FWD && !POL_AC_LOW_IN && !POL_BD_LOW_IN)
        |=> (BRIDGE_OUT_A_OUT && !BRIDGE_OUT_B_OUT && !BRIDGE_OUT_C_OUT
             && BRIDGE_OUT_D_OUT == CAP_PWM_PIN_OUT && BRIDGE_OE_OUT == 4'hF);
    endproperty
    a_fwd: assert property (p_fwd) else $error("forward bridge wrong");

    property p_bridge_idle;
        @(posedge SYS_CLK_IN) disable iff (SRST_IN)
        !pwm_mode |=> (BRIDGE_OE_OUT == 4'h0 && !CAP_PWM_PIN_OUT && !BRIDGE_OUT_A_OUT
            && !BRIDGE_OUT_B_OUT && !BRIDGE_OUT_C_OUT && !BRIDGE_OUT_D_OUT);
    endproperty
    a_bridge_idle: assert property (p_bridge_idle) else $error("bridge not idle");
endmodule

// ==== verification/ecpwm_pulse_src.sv ====
`timescale 1ns/1ps
// Square wave source standing in for the sensor on the capture pin
module ecpwm_pulse_src (
    // Clock
    input  wire logic       clk_in,
    // Phase lengths in cycles, at least one
    input  wire logic [7:0] high_cyc_in,
    input  wire logic [7:0] low_cyc_in,
    // Pin
    output logic            pin_out
);
    logic [7:0] cnt_q = 8'h00;
    initial pin_out = 1'b0;
    always @(posedge clk_in) begin
        if (cnt_q + 8'h01 >= (pin_out ? high_cyc_in : low_cyc_in)) begin
            pin_out <= ~pin_out;
            cnt_q   <= 8'h00;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule

// ==== verification/edge_capture_and_bridge_pwm_bench.sv ====
`timescale 1ns/1ps
`include "ecpwm_cfg.svh"
module edge_capture_and_bridge_pwm_bench;
    logic clk = 1'b0, rst = 1'b1, pac = 1'b0, pbd = 1'b0, en = 1'b0, clr = 1'b0, pin;
    ecpwm_pkg::ecpwm_mode_t   mode = `ECPWM_MODE_OFF;
    ecpwm_pkg::ecpwm_bridge_t br   = `ECPWM_BR_SINGLE;
    logic [15:0] tb = 16'h0000, m_val = 16'h0000, t1, t2, t3, cnt;
    logic [9:0]  per = 10'h007, duty = 10'h000, d;
    logic [7:0]  hi = 8'h03, lo = 8'h03, vh, vl;
    logic        flag, irq, pwm, oa, ob, oc, od, m_prev = 1'b0, m_flag = 1'b0, v;
    logic [3:0]  oe, m_pc = 4'h0, eo, ev;
    logic        rise, fall, sel;
    int          n_fail = 0, tests_run = 0, cyc = 0;
    ecpwm_pkg::ecpwm_mode_t modes [5] = '{`ECPWM_MODE_OFF, `ECPWM_MODE_FALL,
        `ECPWM_MODE_RISE, `ECPWM_MODE_RISE4, `ECPWM_MODE_RISE16};
    initial forever #2 clk = ~clk;
    always @(posedge clk) tb <= tb + 16'h0001;
    ecpwm_pulse_src src (.clk_in(clk), .high_cyc_in(hi), .low_cyc_in(lo), .pin_out(pin));
    ecpwm_top dut (.SYS_CLK_IN(clk), .SRST_IN(rst), .CAPTURE_MODE_FIELD_IN(mode),
        .BRIDGE_MODE_IN(br), .POL_AC_LOW_IN(pac), .POL_BD_LOW_IN(pbd),
        .CAPTURE_IRQ_ENABLE_IN(en), .CAPTURE_FLAG_CLR_IN(clr), .CAPTURE_TIME_BASE_IN(tb),
        .PWM_PERIOD_IN(per), .PWM_DUTY_IN(duty), .CAP_PWM_PIN_IN(pin),
        .CAPTURE_VALUE_HIGH_OUT(vh), .CAPTURE_VALUE_LOW_OUT(vl), .CAPTURE_FLAG_OUT(flag),
        .CAPTURE_IRQ_OUT(irq), .CAP_PWM_PIN_OUT(pwm), .BRIDGE_OUT_A_OUT(oa),
        .BRIDGE_OUT_B_OUT(ob), .BRIDGE_OUT_C_OUT(oc), .BRIDGE_OUT_D_OUT(od), .BRIDGE_OE_OUT(oe));
    // Reference capture model, one cycle behind the sampled inputs
    assign rise = pin & ~m_prev;
    assign fall = ~pin & m_prev;
    assign sel  = (mode == `ECPWM_MODE_RISE && rise) || (mode == `ECPWM_MODE_FALL && fall)
        || (mode == `ECPWM_MODE_RISE4 && rise && m_pc == 4'h3)
        || (mode == `ECPWM_MODE_RISE16 && rise && m_pc == 4'hF);
    always @(posedge clk) begin
        m_prev <= ~rst & pin;
        m_flag <= ~rst & (sel | (m_flag & ~clr));
        m_val  <= rst ? 16'h0000 : (sel ? tb : m_val);
        if (rst || (mode != `ECPWM_MODE_RISE4 && mode != `ECPWM_MODE_RISE16)) begin
            m_pc <= 4'h0;
        end else if (rise) begin
            m_pc <= sel ? 4'h0 : m_pc + 4'h1;
        end
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_fail++;
            end_sim();
        end
    end
    always @(negedge clk) begin
        if (!rst) begin
            chk({vh, vl}, m_val);
            chk({15'h0000, flag}, {15'h0000, m_flag});
            chk({15'h0000, irq}, {15'h0000, m_flag & en});
        end
    end
    task chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task fw_cap(input ecpwm_pkg::ecpwm_mode_t nxt, output logic [15:0] val);
        int n;
        n = 0;
        @(negedge clk);
        while (irq !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        chk({15'h0000, irq}, 16'h0001);
        val = {vh, vl};
        @(posedge clk);
        clr  <= 1'b1;
        mode <= nxt;
        @(posedge clk);
        clr <= 1'b0;
    endtask
    task end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h0000_30C8));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (40) begin
            mode <= `ECPWM_MODE_OFF;
            hi   <= 8'($urandom_range(6, 1));
            lo   <= 8'($urandom_range(6, 1));
            @(posedge clk);
            mode <= modes[$urandom % 5];
            repeat (200) begin
                en  <= 1'($urandom);
                clr <= ($urandom % 8) == 0;
                @(posedge clk);
            end
        end
        $display("random capture test done");
        en <= 1'b1;
        repeat (3) begin
            @(posedge clk);
            mode <= `ECPWM_MODE_OFF;
            clr  <= 1'b1;
            hi   <= 8'($urandom_range(39, 8));
            lo   <= 8'($urandom_range(39, 8));
            repeat (90) @(posedge clk);
            clr  <= 1'b0;
            mode <= `ECPWM_MODE_RISE;
            fw_cap(`ECPWM_MODE_FALL, t1);
            fw_cap(`ECPWM_MODE_RISE, t2);
            fw_cap(`ECPWM_MODE_RISE, t3);
            chk(t2 - t1, {8'h00, hi});
            chk(t3 - t1, {8'h00, hi} + {8'h00, lo});
        end
        $display("pulse measurement test done");
        mode <= `ECPWM_MODE_PWM;
        for (int i = 0; i < 32; i++) begin
            @(posedge clk);
            v = i[0];
            mode <= `ECPWM_MODE_PWM | 4'(i % 4);
            br   <= 2'(i >> 3);
            pac  <= i[1] & i[3];
            pbd  <= i[2] & i[3];
            duty <= v ? 10'h3FF : 10'h000;
            repeat (24) @(negedge clk);
            eo = i[3] ? 4'hF : (i[4] ? 4'h3 : 4'h1);
            ev = i[3] ? (i[4] ? {pbd, ~pac, v ^ pbd, pac} : {v ^ pbd, pac, pbd, ~pac})
                : {2'h0, ~v & i[4], v};
            chk({12'h000, oe}, {12'h000, eo});
            chk({12'h000, {od, oc, ob, oa} & eo}, {12'h000, ev & eo});
        end
        $display("bridge steering test done");
        repeat (4) begin
            @(posedge clk);
            per  <= 10'($urandom_range(1023, 1));
            d     = 10'($urandom_range(1023, 0));
            duty <= d;
            repeat (2200) @(posedge clk);
            cnt = 16'h0000;
            repeat (32'(per) + 1) begin
                @(negedge clk);
                cnt = cnt + {15'h0000, pwm};
            end
            chk(cnt, (d > per) ? {6'h00, per} + 16'h0001 : {6'h00, d});
        end
        $display("duty resolution test done");
        end_sim();
    end
endmodule
